/* File: spbm_assertions.sv */
// Checker watching the link between controller and multiplier device
`timescale 1ns/10ps
module spbm_assertions (
  input wire logic                 sys_clk,
  input wire logic                 srst,
  input wire logic                 multiplicand_load_clear,
  input wire spbm_pkg::spbm_word_t multiplicand_in,
  input wire logic                 multiplier_serial_in,
  input wire logic                 cascade_in,
  input wire logic                 position_select,
  input wire logic                 product_serial_out
);
  import spbm_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Clearing empties the sum register
  clear_out_a : assert property (
    !multiplicand_load_clear |=> !product_serial_out)
    else $error("sum not cleared by load");
  rise_clear_a : assert property (
    $rose(multiplicand_load_clear) |-> !product_serial_out)
    else $error("output not zero at first bit time");
  // Clear lasts one period, run lasts the full count
  clear_pulse_a : assert property (
    $fell(multiplicand_load_clear) |=> multiplicand_load_clear)
    else $error("clear longer than one period");
  run_len_a : assert property (
    $rose(multiplicand_load_clear) |-> multiplicand_load_clear[*8]
    ##1 multiplicand_load_clear[*8] ##1 multiplicand_load_clear)
    else $error("run cut short");
  // Product low bit is X0 when Y0 subtracts
  first_bit_a : assert property (
    $rose(multiplicand_load_clear) |=> product_serial_out ==
    ($past(multiplicand_in[0], 2) & $past(multiplier_serial_in)))
    else $error("wrong first product bit");
  shift_zero_a : assert property (
    $rose(multiplicand_load_clear) && !multiplier_serial_in
    ##1 !multiplier_serial_in |-> !product_serial_out ##1 !product_serial_out)
    else $error("shift only changed the sum");
  sign_hold_a : assert property (
    $rose(multiplicand_load_clear) |->
    ##8 $stable(multiplier_serial_in)[*8])
    else $error("sign bit not repeated");
  casc_low_a : assert property (
    !cascade_in && !position_select)
    else $error("single device cascade inputs not low");
endmodule

/* File: spbm_consts.svh */
// Constants shared by both ends of the serial Booth multiplier link
`ifndef SPBM_CONSTS_SVH
`define SPBM_CONSTS_SVH
`define SPBM_WIDTH       8
`define SPBM_CYCLES      18
`define SPBM_PROD_WIDTH  16
`define SPBM_FIRST_OUT   2
`define SPBM_SIGN_START  8
`define SPBM_SIGN_END    16
`endif

/* File: spbm_ctrl.sv */
// Controlling end: loads multiplicand, streams multiplier, collects product
`timescale 1ns/10ps
`include "spbm_consts.svh"
module spbm_ctrl #(
  parameter int WIDTH = `SPBM_WIDTH,
  parameter int DEPTH = 2
) (
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire spbm_pkg::spbm_word_t req_mcand,
  input  wire spbm_pkg::spbm_word_t req_mplier,
  input  wire logic                cascade_ext,
  input  wire logic                chained,
  output logic                     prod_valid,
  input  wire logic                prod_ready,
  output spbm_pkg::spbm_prod_t     prod_data,
  spbm_link_if.ctrl lnk
);
  import spbm_pkg::*;

  initial begin
    if (WIDTH != `SPBM_WIDTH || DEPTH != 2) begin
      $error("spbm_ctrl: unsupported WIDTH or DEPTH");
    end
  end

  spbm_state_t      st_reg, st_next;
  logic [4:0]       cnt_reg, cnt_next;
  spbm_word_t       mc_reg, mc_next, mp_reg, mp_next;
  spbm_prod_t       acc_reg, acc_next;
  logic             lc_reg, lc_next, y_reg, y_next;
  logic             rdy_reg, rdy_next;
  spbm_prod_t       buf_reg [DEPTH];
  spbm_prod_t       buf_next [DEPTH];
  logic [1:0]       cntb_reg, cntb_next;
  logic             pv_reg, pv_next;
  spbm_prod_t       pd_reg, pd_next;
  logic             done;
  logic             room;

  assign room = (cntb_reg < 2'(DEPTH));

  // Sequencer over the 18 bit times
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    mc_next  = mc_reg;
    mp_next  = mp_reg;
    acc_next = acc_reg;
    lc_next  = lc_reg;
    y_next   = y_reg;
    rdy_next = 1'b0;
    done     = 1'b0;
    unique case (st_reg)
      SPBM_IDLE: begin
        lc_next  = 1'b1;
        rdy_next = room;
        if (req_valid && rdy_reg) begin
          mc_next  = req_mcand;
          mp_next  = req_mplier;
          lc_next  = 1'b0;
          rdy_next = 1'b0;
          st_next  = SPBM_LOAD;
        end
      end
      SPBM_LOAD: begin
        lc_next  = 1'b1;
        y_next   = mp_reg[0];  // see RULE_08
        cnt_next = 5'h01;
        st_next  = SPBM_RUN;
      end
      SPBM_RUN: begin
        cnt_next = cnt_reg + 5'h01;
        // Sign bit held from bit time eight: see RULE_10
        if (cnt_reg < 5'(`SPBM_SIGN_START)) begin
          y_next = mp_reg[cnt_reg[2:0]];  // see RULE_08
        end else begin
          y_next = mp_reg[WIDTH-1];
        end
        if (cnt_reg >= 5'(`SPBM_FIRST_OUT)) begin
          acc_next = {lnk.product_serial_out,
                      acc_reg[`SPBM_PROD_WIDTH-1:1]};
        end
        // Last capture ends the multiply: see RULE_11
        if (cnt_reg == 5'(`SPBM_CYCLES - 1)) begin
          done    = 1'b1;
          st_next = SPBM_IDLE;
        end
      end
      default: st_next = SPBM_IDLE;
    endcase
  end

  // Two-entry product buffer
  always_comb begin
    cntb_next = cntb_reg;
    pv_next   = pv_reg;
    pd_next   = pd_reg;
    for (int i = 0; i < DEPTH; i++) begin
      buf_next[i] = buf_reg[i];
    end
    if (pv_reg && prod_ready) begin
      pv_next = 1'b0;
    end
    if (!pv_next && cntb_reg != 2'h0) begin
      pv_next     = 1'b1;
      pd_next     = buf_reg[0];
      buf_next[0] = buf_reg[1];
      cntb_next   = cntb_reg - 2'h1;
    end
    if (done) begin
      buf_next[cntb_next[0]] = {lnk.product_serial_out,
                                acc_reg[`SPBM_PROD_WIDTH-1:1]};
      cntb_next = cntb_next + 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg   <= SPBM_IDLE;
      cnt_reg  <= '0;
      mc_reg   <= '0;
      mp_reg   <= '0;
      acc_reg  <= '0;
      lc_reg   <= 1'b1;
      y_reg    <= 1'b0;
      rdy_reg  <= 1'b0;
      cntb_reg <= '0;
      pv_reg   <= 1'b0;
      pd_reg   <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        buf_reg[i] <= '0;
      end
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      mc_reg   <= mc_next;
      mp_reg   <= mp_next;
      acc_reg  <= acc_next;
      lc_reg   <= lc_next;
      y_reg    <= y_next;
      rdy_reg  <= rdy_next;
      cntb_reg <= cntb_next;
      pv_reg   <= pv_next;
      pd_reg   <= pd_next;
      for (int i = 0; i < DEPTH; i++) begin
        buf_reg[i] <= buf_next[i];
      end
    end
  end

  // Link drive; chained parts take cascade from the higher part
  assign lnk.multiplicand_load_clear = lc_reg;
  assign lnk.multiplicand_in = mc_reg;  // Full width used: see RULE_12
  assign lnk.multiplier_serial_in = y_reg;
  assign lnk.cascade_in = chained ? cascade_ext : 1'b0;  // see RULE_07
  assign lnk.position_select = chained;  // see RULE_14
  assign req_ready  = rdy_reg;
  assign prod_valid = pv_reg;
  assign prod_data  = pd_reg;
endmodule

/* File: spbm_device.sv */
// Serial/parallel two's complement Booth multiplier cell array
// How it works
// RULE_01 - Low load_clear keeps multiplicand latches open
// RULE_02 - Rising load_clear freezes multiplicand value
// RULE_03 - Low load_clear clears prev bit, carries, sums
// RULE_04 - Bit pair selects shift, add or subtract
// RULE_05 - Carry-save cells, own sum and carry flops
// RULE_06 - Top cell uses cascade_in, position_select
// RULE_07 - Chain: cascade_in from higher product output
// RULE_08 - Multiplier bits LSB first after load
// RULE_09 - Product LSB out two bit times after load
// RULE_10 - Sign bit repeated bit times eight to sixteen
// RULE_11 - Full 8x8 multiply takes 18 clocks
// RULE_12 - Upper multiplicand inputs sign-extended when chained; the ctrl drives the full mc_reg word whether chained or not
// RULE_13 - Operands and product are two's complement
// RULE_14 - Top device cascade and select low
// RULE_15 - Flops change only on clock edges
`timescale 1ns/10ps
`include "spbm_consts.svh"
module spbm_device #(
  parameter int WIDTH = `SPBM_WIDTH
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  spbm_link_if.device lnk
);
  import spbm_pkg::*;

  initial begin
    if (WIDTH != `SPBM_WIDTH) begin
      $error("spbm_device: WIDTH must match the link word width");
    end
  end

  // One guard cell above the word so minus the most negative value fits
  localparam int CW = WIDTH + 1;

  // Cell state
  logic [WIDTH-1:0] mcand_reg, mcand_next;
  logic [CW-1:0]    neg_reg, neg_next;
  logic [CW-1:0]    sum_reg, sum_next;
  logic [CW-1:0]    carry_reg, carry_next;
  logic             prev_reg, prev_next;
  logic             add_en;
  logic             sub_en;
  logic [CW-1:0]    operand;
  logic [CW-1:0]    upper;

  // Booth recoding of the current and previous multiplier bit
  assign add_en = !lnk.multiplier_serial_in && prev_reg;  // see RULE_04
  assign sub_en = lnk.multiplier_serial_in && !prev_reg;  // see RULE_04
  // Subtraction adds the stored negated multiplicand, sign extended
  assign operand = sub_en ? neg_reg :  // see RULE_13
                   add_en ? {mcand_reg[WIDTH-1], mcand_reg} : '0;

  // Stage inputs: each cell below the top takes the sum of its upper neighbour
  genvar gi;
  generate
    for (gi = 0; gi < CW - 1; gi++) begin : g_up
      assign upper[gi] = sum_reg[gi+1];
    end
  endgenerate
  // Top cell: select picks cascade input instead of its own sum as the sign
  assign upper[CW-1] = lnk.position_select ?
                       lnk.cascade_in : sum_reg[CW-1];  // see RULE_06

  // Next state of latches, carry-save cells and previous bit
  always_comb begin
    mcand_next = mcand_reg;
    neg_next   = neg_reg;
    sum_next   = sum_reg;
    carry_next = carry_reg;
    prev_next  = prev_reg;
    if (!lnk.multiplicand_load_clear) begin
      mcand_next = lnk.multiplicand_in;  // see RULE_01
      // Negated copy taken once while loading, not per bit time
      neg_next   = CW'(~{lnk.multiplicand_in[WIDTH-1],
                         lnk.multiplicand_in} + 1'b1);
      sum_next   = '0;                   // see RULE_03
      carry_next = '0;
      prev_next  = 1'b0;
    end else begin
      // Latch holds while high: see RULE_02
      for (int i = 0; i < CW; i++) begin
        // Per-cell full adder without a carry chain: see RULE_05
        sum_next[i]   = upper[i] ^ operand[i] ^ carry_reg[i];
        carry_next[i] = (upper[i] & operand[i]) |
                        (upper[i] & carry_reg[i]) |
                        (operand[i] & carry_reg[i]);
      end
      prev_next = lnk.multiplier_serial_in;  // see RULE_15
    end
  end

  // Registered state, every edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mcand_reg <= '0;
      neg_reg   <= '0;
      sum_reg   <= '0;
      carry_reg <= '0;
      prev_reg  <= 1'b0;
    end else begin
      mcand_reg <= mcand_next;
      neg_reg   <= neg_next;
      sum_reg   <= sum_next;
      carry_reg <= carry_next;
      prev_reg  <= prev_next;
    end
  end

  // Bottom sum flop drives the serial product out
  assign lnk.product_serial_out = sum_reg[0];  // see RULE_09
endmodule

/* File: spbm_link_if.sv */
// Link between the multiplier device and its controlling logic
`timescale 1ns/10ps
interface spbm_link_if;
  import spbm_pkg::*;
  logic       multiplicand_load_clear;
  spbm_word_t multiplicand_in;
  logic       multiplier_serial_in;
  logic       cascade_in;
  logic       position_select;
  logic       product_serial_out;
  modport device (
    input  multiplicand_load_clear,
    input  multiplicand_in,
    input  multiplier_serial_in,
    input  cascade_in,
    input  position_select,
    output product_serial_out
  );
  modport ctrl (
    output multiplicand_load_clear,
    output multiplicand_in,
    output multiplier_serial_in,
    output cascade_in,
    output position_select,
    input  product_serial_out
  );
endinterface

/* File: spbm_pkg.sv */
// Types shared by both ends of the serial Booth multiplier link
`include "spbm_consts.svh"
package spbm_pkg;
  typedef logic [`SPBM_WIDTH-1:0]      spbm_word_t;
  typedef logic [`SPBM_PROD_WIDTH-1:0] spbm_prod_t;
  typedef enum logic [2:0] {
    SPBM_IDLE = 3'h1,
    SPBM_LOAD = 3'h2,
    SPBM_RUN  = 3'h4
  } spbm_state_t;
endpackage

/* File: tb_serial_parallel_booth_multiplier.sv */
// Bench joining controller and device, checking serial products
`timescale 1ns/10ps
module tb_serial_parallel_booth_multiplier;
  import spbm_pkg::*;
  logic       sys_clk    = 1'b0;
  logic       srst       = 1'b1;
  logic       req_valid  = 1'b0;
  logic       prod_ready = 1'b1;
  logic [1:0] bp_mode    = 2'h0;
  spbm_word_t req_mcand  = 8'h00;
  spbm_word_t req_mplier = 8'h00;
  logic       req_ready;
  logic       prod_valid;
  spbm_prod_t prod_data;
  spbm_prod_t exp_q[$];
  int         n_mismatch   = 0;
  int         total_checks = 0;
  int         n;
  spbm_prod_t corner[8] = '{16'h0000, 16'h7F7F, 16'h8080, 16'h807F,
                            16'hFF01, 16'h01FF, 16'h8001, 16'h55AA};
  spbm_link_if lnk ();
  spbm_device i_spbm_device (.sys_clk(sys_clk), .srst(srst), .lnk(lnk.device));
  spbm_ctrl i_spbm_ctrl (.sys_clk(sys_clk), .srst(srst),
    .req_valid(req_valid), .req_ready(req_ready), .req_mcand(req_mcand),
    .req_mplier(req_mplier), .cascade_ext(1'b0), .chained(1'b0),
    .prod_valid(prod_valid), .prod_ready(prod_ready),
    .prod_data(prod_data), .lnk(lnk.ctrl));
  spbm_assertions i_spbm_assertions (.sys_clk(sys_clk), .srst(srst),
    .multiplicand_load_clear(lnk.multiplicand_load_clear),
    .multiplicand_in(lnk.multiplicand_in),
    .multiplier_serial_in(lnk.multiplier_serial_in),
    .cascade_in(lnk.cascade_in), .position_select(lnk.position_select),
    .product_serial_out(lnk.product_serial_out));
  // Clock, 5 ns period
  always #2.5 sys_clk = ~sys_clk;
  task automatic check_prod(string what, spbm_prod_t e, spbm_prod_t g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h got %h", what, e, g);
    end
  endtask
  task automatic check_bit(string what, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %b got %b", what, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One request, expected signed product noted on take
  task automatic send(spbm_word_t a, spbm_word_t b);
    int k;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_mcand <= a;
    req_mplier <= b;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 200);
    if (req_ready === 1'b1) begin
      exp_q.push_back(16'($signed(a)) * 16'($signed(b)));
    end
    else check_bit("req_ready", 1'b1, req_ready);
    req_valid <= 1'b0;
  endtask
  // Sole driver of prod_ready: steady, random or stalled
  always @(posedge sys_clk) begin
    prod_ready <= (bp_mode == 2'h0) ? 1'b1 :
                  (bp_mode == 2'h1) ? 1'($urandom) : 1'b0;
  end
  // Result watcher pops oldest expected product
  always @(posedge sys_clk) begin
    if (srst === 1'b0 && prod_valid === 1'b1 && prod_ready === 1'b1) begin
      if (exp_q.size() == 0) check_bit("extra product", 1'b0, 1'b1);
      else check_prod("product", exp_q.pop_front(), prod_data);
    end
  end
  // Wait for the queue to drain, bounded
  task automatic drain();
    n = 0;
    while (exp_q.size() != 0 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    check_bit("drained", 1'b1, exp_q.size() == 0);
  endtask
  // 31 runs of about 20 cycles; far more allowed
  initial begin
    #100000;
    check_bit("watchdog", 1'b0, 1'b1);
    finish_test();
  end
  initial begin
    void'($urandom(11158));
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    // Extreme signs and all Booth bit pairs
    foreach (corner[i]) send(corner[i][15:8], corner[i][7:0]);
    // Random operands under random stalls
    bp_mode <= 2'h1;
    repeat (20) send(8'($urandom), 8'($urandom));
    drain();
    // Fill output register and both buffer entries while stalled
    bp_mode <= 2'h2;
    send(8'h80, 8'hFF);
    send(8'h7F, 8'h80);
    send(8'h81, 8'h7F);
    repeat (30) @(posedge sys_clk);
    check_bit("req_ready full", 1'b0, req_ready);
    check_bit("prod_valid held", 1'b1, prod_valid);
    bp_mode <= 2'h0;
    drain();
    finish_test();
  end
endmodule
